/* hdl/input_temp_status_regs.sv */
// Purpose: Latched input-supply and temperature status registers
// Assumes: Command decode and PMBus framing done upstream; strobes are one-cycle
// Notes:   Read data is registered and appears one cycle after the read strobe
//          A set and a clear in the same cycle leave the flag set
//          Responses track the gated live condition, not the latched flags
//          The power-up arm is cleared by reset only, never by a wipe
//
// Functional notes
// [RL1] Registers at command codes 7Ch and 7Dh
// [RL2] Flags stay latched after condition goes away
// [RL3] Wipe command or output turn-on clears all
// [RL4] Written one bits clear matching flags
// [RL5] Alert mask never blocks flag latching
// [RL6] Disable bit blocks flag and protective response
// [RL7] Input bit 7 latches overvoltage fault
// [RL8] Input bit 3 reports low input voltage
// [RL9] No low-input latch before first turn-on
// [RL10] Later drops below turn-off latch and alert
// [RL11] Temperature bit 7 latches overtemp fault
// [RL12] Temperature bit 6 latches overtemp warning
// [RL13] Unsupported bits read as zero
// [RL14] Zero writes and read-only writes ignored
`timescale 1ns/1ps
`default_nettype none

module input_temp_status_regs
  import status_regs_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] cmd_code_in,
  input  wire logic [7:0] wr_data_in,
  input  wire logic       fault_flag_wipe_command_in,
  input  wire logic       output_turn_on_in,
  input  wire logic       input_ov_event_in,
  input  wire logic       input_above_turn_on_in,
  input  wire logic       input_below_turn_off_in,
  input  wire logic       overtemp_fault_event_in,
  input  wire logic       overtemp_warning_event_in,
  input  wire logic       input_ov_disable_in,
  input  wire logic       input_uv_disable_in,
  input  wire logic       overtemp_fault_disable_in,
  input  wire logic       overtemp_warning_disable_in,
  input  wire logic       alert_mask_setting_in,
  output logic [7:0]      rd_data_out,
  output logic            rd_valid_out,
  output logic            input_ov_response_out,
  output logic            input_uv_response_out,
  output logic            overtemp_fault_response_out,
  output logic            overtemp_warning_response_out,
  output logic            input_status_alert_out
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic       input_overvoltage_flag_r;
  logic       input_undervoltage_flag_r;
  logic       overtemp_fault_flag_r;
  logic       overtemp_warning_flag_r;
  logic       input_seen_on_r;
  logic       wipe_all;
  logic       wr_input;
  logic       wr_temp;
  logic [7:0] input_byte;
  logic [7:0] temp_byte;

  // [RL3] Global clear sources
  assign wipe_all = fault_flag_wipe_command_in | output_turn_on_in;
  // [RL1] Command code decode
  assign wr_input = reg_wr_in && (cmd_code_in == CMD_INPUT_STATUS);
  assign wr_temp  = reg_wr_in && (cmd_code_in == CMD_TEMP_STATUS);

  // ----------------------------------------------------------------
  // Per-bit clear strobes
  // ----------------------------------------------------------------
  // One strobe per byte position of each register. Only the supported
  // positions feed a flag; a one written to a read-only position lands
  // on a strobe that nothing reads, so the write has no effect there.
  logic [7:0] input_clr;
  logic [7:0] temp_clr;

  // [RL4] Written ones clear
  // [RL14] Zero bits ignored
  for (genvar bit_idx = 0; bit_idx < $bits(input_clr); bit_idx++) begin : g_clr
    assign input_clr[bit_idx] = wipe_all | (wr_input & wr_data_in[bit_idx]);
    assign temp_clr[bit_idx]  = wipe_all | (wr_temp & wr_data_in[bit_idx]);
  end

  // [RL13] Unsupported positions tied to zero
  always_comb begin
    input_byte = BYTE_ZERO;
    input_byte[INPUT_OV_BIT] = input_overvoltage_flag_r;
    input_byte[INPUT_UV_BIT] = input_undervoltage_flag_r;
    temp_byte = BYTE_ZERO;
    temp_byte[TEMP_FAULT_BIT] = overtemp_fault_flag_r;
    temp_byte[TEMP_WARN_BIT]  = overtemp_warning_flag_r;
  end

  // ----------------------------------------------------------------
  // Power-up qualifier
  // ----------------------------------------------------------------
  // The low-input comparator is already true while the supply ramps,
  // so latching it then would leave a stale flag on every power-up.
  // Limitation: a brownout that never reaches turn-on stays unflagged.
  // [RL9] Arm low-input latching after first turn-on
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      input_seen_on_r <= FLAG_RESET;
    end else if (input_above_turn_on_in) begin
      input_seen_on_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Latched flags: set wins over any clear in the same cycle
  // ----------------------------------------------------------------
  // Alert mask is deliberately not an input to any flag.
  // [RL5] Mask ignored for latching
  logic ov_set;
  logic uv_set;
  logic otf_set;
  logic otw_set;
  // [RL6] Disable blocks the flag set
  assign ov_set  = input_ov_event_in & ~input_ov_disable_in;
  // [RL10] Qualified low-input event
  assign uv_set  = input_below_turn_off_in & input_seen_on_r & ~input_uv_disable_in;
  assign otf_set = overtemp_fault_event_in & ~overtemp_fault_disable_in;
  assign otw_set = overtemp_warning_event_in & ~overtemp_warning_disable_in;

  // [RL7] Input overvoltage flag
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      input_overvoltage_flag_r <= FLAG_RESET;
    end else if (ov_set) begin
      // [RL2] Hold once set
      input_overvoltage_flag_r <= 1'b1;
    end else if (input_clr[INPUT_OV_BIT]) begin
      // [RL4] Write one clears
      input_overvoltage_flag_r <= 1'b0;
    end
  end

  // [RL8] Low input flag
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      input_undervoltage_flag_r <= FLAG_RESET;
    end else if (uv_set) begin
      input_undervoltage_flag_r <= 1'b1;
    end else if (input_clr[INPUT_UV_BIT]) begin
      input_undervoltage_flag_r <= 1'b0;
    end
  end

  // [RL11] Overtemp fault flag
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      overtemp_fault_flag_r <= FLAG_RESET;
    end else if (otf_set) begin
      overtemp_fault_flag_r <= 1'b1;
    end else if (temp_clr[TEMP_FAULT_BIT]) begin
      overtemp_fault_flag_r <= 1'b0;
    end
  end

  // [RL12] Overtemp warning flag
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      overtemp_warning_flag_r <= FLAG_RESET;
    end else if (otw_set) begin
      overtemp_warning_flag_r <= 1'b1;
    end else if (temp_clr[TEMP_WARN_BIT]) begin
      // [RL14] Zero bits leave flags alone
      overtemp_warning_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Responses and alert
  // ----------------------------------------------------------------
  // Responses follow the gated live condition, not the latched flag,
  // so the power stage reacts even before software looks.
  // [RL6] Overvoltage response gated
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      input_ov_response_out <= FLAG_RESET;
    end else begin
      input_ov_response_out <= ov_set;
    end
  end

  // [RL6] Low-input response gated
  // Shares the power-up arm so the ramp does not trip a response.
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      input_uv_response_out <= FLAG_RESET;
    end else begin
      input_uv_response_out <= uv_set;
    end
  end

  // [RL6] Overtemp fault response gated
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      overtemp_fault_response_out <= FLAG_RESET;
    end else begin
      overtemp_fault_response_out <= otf_set;
    end
  end

  // [RL6] Overtemp warning response gated
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      overtemp_warning_response_out <= FLAG_RESET;
    end else begin
      overtemp_warning_response_out <= otw_set;
    end
  end

  // Alert request from this bank; the mask gates only the alert, never flags
  logic any_flag;

  // Any latched flag, before the mask
  assign any_flag = input_overvoltage_flag_r |
                    input_undervoltage_flag_r |
                    overtemp_fault_flag_r |
                    overtemp_warning_flag_r;

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      input_status_alert_out <= FLAG_RESET;
    end else begin
      // [RL10] Latched low input raises alert
      input_status_alert_out <= ~alert_mask_setting_in & any_flag;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // [RL1] Read answer strobe
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_valid_out <= FLAG_RESET;
    end else begin
      rd_valid_out <= reg_rd_in;
    end
  end

  // Data holds between reads so a slow host can pick it up late.
  // [RL1] Read byte mux
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= BYTE_ZERO;
    end else begin
      if (reg_rd_in) begin
        case (cmd_code_in)
          CMD_INPUT_STATUS: rd_data_out <= input_byte;
          CMD_TEMP_STATUS:  rd_data_out <= temp_byte;
          default:          rd_data_out <= BYTE_ZERO;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* shared/status_regs_pkg.sv */
// Purpose: Constants for the input and temperature status register bank
// Assumes: Byte-wide registers addressed by PMBus command code
// Notes:   Field positions and reset values shared by design and bench
package status_regs_pkg;
  localparam logic [7:0] CMD_INPUT_STATUS = 8'h7C;
  localparam logic [7:0] CMD_TEMP_STATUS  = 8'h7D;
  localparam int unsigned INPUT_OV_BIT    = 7;
  localparam int unsigned INPUT_UV_BIT    = 3;
  localparam int unsigned TEMP_FAULT_BIT  = 7;
  localparam int unsigned TEMP_WARN_BIT   = 6;
  localparam logic        FLAG_RESET      = 1'b0;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;
endpackage

/* bench/input_temp_status_regs_chk.sv */
// Purpose: Port checker for the status register bank
// Assumes: One clock, asynchronous active-high reset
// Notes:   Attached by bind below
`timescale 1ns/1ps
`default_nettype none
module input_temp_status_regs_chk (
  input wire logic core_clk_in, reset_in, reg_rd_in, rd_valid_out,
  input wire logic input_ov_event_in, input_ov_disable_in, input_ov_response_out,
  input wire logic alert_mask_setting_in, input_status_alert_out,
  input wire logic input_below_turn_off_in, input_uv_disable_in, input_uv_response_out,
  input wire logic overtemp_fault_event_in, overtemp_fault_disable_in,
  input wire logic overtemp_fault_response_out,
  input wire logic overtemp_warning_event_in, overtemp_warning_disable_in,
  input wire logic overtemp_warning_response_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  property p_rd_ans; reg_rd_in |=> rd_valid_out; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_src; rd_valid_out |-> $past(reg_rd_in); endproperty
  a_rd_src: assert property (p_rd_src) else $error("stray read valid");
  property p_rd_one; reg_rd_in ##1 !reg_rd_in |=> !rd_valid_out; endproperty
  a_rd_one: assert property (p_rd_one) else $error("read valid too long");
  property p_ov_on; input_ov_event_in && !input_ov_disable_in |=> input_ov_response_out;
  endproperty
  a_ov_on: assert property (p_ov_on) else $error("no overvoltage response");
  property p_ov_dis; input_ov_disable_in |=> !input_ov_response_out; endproperty
  a_ov_dis: assert property (p_ov_dis) else $error("disabled response seen");
  property p_ov_off; !input_ov_event_in |=> !input_ov_response_out; endproperty
  a_ov_off: assert property (p_ov_off) else $error("response without event");
  property p_mask; alert_mask_setting_in |=> !input_status_alert_out; endproperty
  a_mask: assert property (p_mask) else $error("masked alert seen");
  property p_alert;
    input_ov_event_in && !input_ov_disable_in ##1 !alert_mask_setting_in
      |=> input_status_alert_out;
  endproperty
  a_alert: assert property (p_alert) else $error("latched flag gave no alert");
  property p_uv_off; !input_below_turn_off_in || input_uv_disable_in |=> !input_uv_response_out;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("low-input response leaked");
  property p_otf_on; overtemp_fault_event_in && !overtemp_fault_disable_in
    |=> overtemp_fault_response_out; endproperty
  a_otf_on: assert property (p_otf_on) else $error("no overtemp fault response");
  property p_otf_off; !overtemp_fault_event_in || overtemp_fault_disable_in
    |=> !overtemp_fault_response_out; endproperty
  a_otf_off: assert property (p_otf_off) else $error("overtemp fault response leaked");
  property p_otw_on; overtemp_warning_event_in && !overtemp_warning_disable_in
    |=> overtemp_warning_response_out; endproperty
  a_otw_on: assert property (p_otw_on) else $error("no overtemp warning response");
  property p_otw_off; !overtemp_warning_event_in || overtemp_warning_disable_in
    |=> !overtemp_warning_response_out; endproperty
  a_otw_off: assert property (p_otw_off) else $error("overtemp warning response leaked");
  c_read: cover property (reg_rd_in ##1 rd_valid_out);
  c_alert: cover property ($rose(input_status_alert_out));
  c_resp: cover property (input_ov_response_out);
endmodule
bind input_temp_status_regs input_temp_status_regs_chk u_chk (.core_clk_in, .reset_in,
  .reg_rd_in, .rd_valid_out, .input_ov_event_in, .input_ov_disable_in,
  .input_ov_response_out, .alert_mask_setting_in, .input_status_alert_out,
  .input_below_turn_off_in, .input_uv_disable_in, .input_uv_response_out,
  .overtemp_fault_event_in, .overtemp_fault_disable_in, .overtemp_fault_response_out,
  .overtemp_warning_event_in, .overtemp_warning_disable_in, .overtemp_warning_response_out);
`default_nettype wire

/* bench/status_host.sv */
// Purpose: Host side issuing read-byte and write-byte requests
// Assumes: Requests change just after a rising edge
// Notes:   Released lines show inverted data, not the last value
`timescale 1ns/1ps
`default_nettype none
module status_host (
  input  wire logic       core_clk_in,
  input  wire logic       rd_valid_in,
  input  wire logic [7:0] rd_data_in,
  output logic            wr_out = 1'b0,
  output logic            rd_out = 1'b0,
  output logic [7:0]      cmd_out = 8'h00,
  output logic [7:0]      data_out = 8'h00
);
  task automatic wr_byte(input logic [7:0] c, input logic [7:0] d);
    @(posedge core_clk_in);
    {wr_out, cmd_out, data_out} <= {1'b1, c, d};
    @(posedge core_clk_in);
    {wr_out, cmd_out, data_out} <= {1'b0, ~c, ~d};
  endtask
  task automatic rd_byte(input logic [7:0] c, output logic [7:0] d);
    @(posedge core_clk_in);
    {rd_out, cmd_out} <= {1'b1, c};
    @(posedge core_clk_in);
    {rd_out, cmd_out} <= {1'b0, ~c};
    #1;
    for (int n = 0; n < 4 && rd_valid_in !== 1'b1; n++) begin
      @(posedge core_clk_in);
      #1;
    end
    d = (rd_valid_in === 1'b1) ? rd_data_in : 8'hXX;
  endtask
endmodule
`default_nettype wire

/* bench/input_temp_status_regs_tb.sv */
// Purpose: Self-checking bench for the status register bank
// Assumes: ev bits 0 ov,1 above,2 below,3 otf,4 otw,5-8 disables,9 mask,10 wipe,11 on
// Notes:   Conditions are held for one cycle then dropped
`timescale 1ns/1ps
`default_nettype none
module input_temp_status_regs_tb;
  import status_regs_pkg::*;
  logic        core_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [11:0] ev = 12'h000;
  logic        wr, rd, vld;
  logic [7:0]  cmd, wd, rdat, got;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #5 core_clk_in = ~core_clk_in;
  input_temp_status_regs u_dut (.core_clk_in, .reset_in, .reg_wr_in(wr), .reg_rd_in(rd),
    .cmd_code_in(cmd), .wr_data_in(wd), .fault_flag_wipe_command_in(ev[10]),
    .output_turn_on_in(ev[11]), .input_ov_event_in(ev[0]), .input_above_turn_on_in(ev[1]),
    .input_below_turn_off_in(ev[2]), .overtemp_fault_event_in(ev[3]),
    .overtemp_warning_event_in(ev[4]), .input_ov_disable_in(ev[5]),
    .input_uv_disable_in(ev[6]), .overtemp_fault_disable_in(ev[7]),
    .overtemp_warning_disable_in(ev[8]), .alert_mask_setting_in(ev[9]),
    .rd_data_out(rdat), .rd_valid_out(vld), .input_ov_response_out(),
    .input_uv_response_out(), .overtemp_fault_response_out(),
    .overtemp_warning_response_out(), .input_status_alert_out());
  status_host u_host (.core_clk_in, .rd_valid_in(vld), .rd_data_in(rdat), .wr_out(wr),
    .rd_out(rd), .cmd_out(cmd), .data_out(wd));
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] c, input logic [7:0] exp);
    u_host.rd_byte(c, got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: cmd %h read %h want %h", $time, c, got, exp);
    end
  endtask
  task automatic drive(input logic [11:0] v);
    @(posedge core_clk_in);
    ev <= v;
    @(posedge core_clk_in);
    ev <= 12'h000;
  endtask
  always @(posedge core_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      bad_count++;
      results();
    end
  end
  initial begin
    repeat (10) @(posedge core_clk_in);
    reset_in <= 1'b0;
    chk(CMD_INPUT_STATUS, BYTE_ZERO);
    chk(CMD_TEMP_STATUS, BYTE_ZERO);
    drive(12'h004);
    chk(CMD_INPUT_STATUS, 8'h00);
    drive(12'h002);
    drive(12'h004);
    chk(CMD_INPUT_STATUS, 8'h08);
    drive(12'h201);
    chk(CMD_INPUT_STATUS, 8'h88);
    $display("test input latching done");
    u_host.wr_byte(CMD_INPUT_STATUS, 8'h08);
    chk(CMD_INPUT_STATUS, 8'h80);
    u_host.wr_byte(CMD_INPUT_STATUS, 8'h77);
    chk(CMD_INPUT_STATUS, 8'h80);
    drive(12'h008);
    chk(CMD_TEMP_STATUS, 8'h80);
    drive(12'h010);
    u_host.wr_byte(CMD_TEMP_STATUS, 8'h3F);
    chk(CMD_TEMP_STATUS, 8'hC0);
    chk(8'h7E, BYTE_ZERO);
    $display("test write clear done");
    drive(12'h400);
    chk(CMD_TEMP_STATUS, BYTE_ZERO);
    chk(CMD_INPUT_STATUS, BYTE_ZERO);
    drive(12'h010);
    drive(12'h800);
    chk(CMD_TEMP_STATUS, BYTE_ZERO);
    drive(12'h1FF);
    chk(CMD_INPUT_STATUS, BYTE_ZERO);
    chk(CMD_TEMP_STATUS, BYTE_ZERO);
    $display("test bulk clear and disable done");
    results();
  end
endmodule
`default_nettype wire
